// [src/rcsf_top.sv]
// receive compensation filter and pulse shaping filter for one channel
`timescale 1ns/1ps
`default_nettype none
module rcsf_top
	import rcsf_pkg::*;
#(
	parameter int NT = 64  // taps per filter memory
)(
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          ce_i,          // freezes all state when low
	input  wire logic [RAW-1:0] addr_i,
	input  wire logic [DW-1:0] wdata_i,
	input  wire logic          we_i,
	input  wire logic          re_i,
	output logic      [DW-1:0] rdata_o,
	input  wire logic          in_valid_i,    // comb filter sample strobe
	input  wire logic [DW-1:0] in_a_i,
	input  wire logic [DW-1:0] in_b_i,
	input  wire logic          strap_valid_i, // from even neighbour
	input  wire logic [DW-1:0] strap_data_i,
	input  wire logic          psum_valid_i,  // from odd neighbour
	input  wire logic [AW-1:0] psum_i,
	output logic               strap_valid_o,
	output logic      [DW-1:0] strap_data_o,
	output logic               psum_valid_o,
	output logic      [AW-1:0] psum_o,
	output logic               out_valid_o,
	output logic      [DW-1:0] out_a_o,
	output logic      [DW-1:0] out_b_o
);
	// ==================================================================
	// control registers
	logic [4:0] cf_taps_reg;   // compensation tap field
	logic       cf_sym_reg;    // symmetry option
	logic       cf_gain_reg;   // compensation gain bit
	logic [3:0] pf_taps_reg;   // shaping tap field
	logic [2:0] pf_gain_reg;   // shaping gain shift
	logic       cdma_reg;      // two sub-channels per channel
	logic [1:0] dbl_reg;       // double length role
	logic [4:0] cic_reg;       // comb ratio field
	logic [DW-1:0] rdata_reg;
	// coefficient memories, compensation split in high and low parts
	logic [DW-3:0] cf_hi_mem [NT];
	logic [1:0]    cf_lo_mem [NT];
	logic [DW-1:0] pf_mem    [NT];
	logic [1:0] page;
	logic [5:0] idx;           // upper_space_bit and five address bits
	assign page = addr_i[7:6];
	assign idx  = addr_i[5:0];
	// software writes, with coefficient loading
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cf_taps_reg <= CF_TAPS_RST;
			cf_sym_reg  <= 1'b0;
			cf_gain_reg <= 1'b0;
			pf_taps_reg <= PF_TAPS_RST;
			pf_gain_reg <= 3'h0;
			cdma_reg    <= 1'b0;
			dbl_reg     <= DBL_NORMAL;
			cic_reg     <= CIC_RST;
			for (int i = 0; i < NT; i++)
			begin
				cf_hi_mem[i] <= '0;
				cf_lo_mem[i] <= '0;
				pf_mem[i]    <= '0;
			end
		end
		else if (ce_i && we_i)
		begin
			unique case (page)
				PAGE_CTRL:
				begin
					if (idx == REG_CFCFG)
					begin
						cf_taps_reg <= wdata_i[4:0];
						cf_sym_reg  <= wdata_i[CF_SYM_BIT];
						cf_gain_reg <= wdata_i[CF_GAIN_BIT];
					end
					if (idx == REG_PFCFG)
					begin
						pf_taps_reg <= wdata_i[3:0];
						pf_gain_reg <= wdata_i[PF_GAIN_LSB +: 3];
					end
					if (idx == REG_MODE)
					begin
						cdma_reg <= wdata_i[0];
						dbl_reg  <= wdata_i[MODE_DBL_LSB +: 2];
						cic_reg  <= wdata_i[MODE_CIC_LSB +: 5];
					end
				end
				PAGE_CFHI: cf_hi_mem[idx] <= wdata_i[DW-3:0];
				PAGE_CFLO: cf_lo_mem[idx] <= wdata_i[1:0];
				PAGE_PF:   pf_mem[idx]    <= wdata_i;
			endcase
		end
	end
	// ==================================================================
	// derived lengths and limits
	logic [6:0] cf_raw, cf_len, cf_iters, cf_lim, pf_raw, pf_min, pf_len;
	logic [7:0] pf_total;      // whole pair length when strapped
	logic [5:0] ncic;          // comb decimation ratio
	logic       cf_over;       // length above the comb limit
	always_comb
	begin
		cf_raw   = 7'({cf_taps_reg, 1'b0}) + CF_STEP;
		cf_len   = (cf_raw < CF_MIN_TAPS) ? CF_MIN_TAPS : cf_raw;
		cf_iters = cf_sym_reg ? {1'b0, cf_len[6:1]} : cf_len;
		pf_raw   = 7'({pf_taps_reg, 2'b00}) + PF_STEP;
		pf_min   = cdma_reg ? PF_MIN_CDMA : PF_MIN_UMTS;
		pf_len   = (pf_raw < pf_min) ? pf_min : pf_raw;
		// a strapped pair runs the same length in each half
		pf_total = (dbl_reg != DBL_NORMAL) ? {pf_len, 1'b0} : {1'b0, pf_len};
		ncic     = 6'({1'b0, cic_reg}) + 6'h01;
		// only reported: the host is trusted to respect it
		cf_lim   = cic_reg[0] ? {ncic, 1'b0} : {1'b0, cic_reg, 1'b0};
		cf_over  = cdma_reg && (cf_len > cf_lim);
	end
	// ==================================================================
	// compensation delay lines and decimation phase
	logic [DW-1:0] cf_dl_a [NT];
	logic [DW-1:0] cf_dl_b [NT];
	logic          cf_phase_reg; // second sample of a pair starts a sum
	logic          cf_start;
	rcsf_seq_t     cf_st_reg;
	assign cf_start = in_valid_i && cf_phase_reg && (cf_st_reg == SEQ_IDLE);
	// samples shift at the input rate, sums run at half of it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cf_phase_reg <= 1'b0;
			for (int i = 0; i < NT; i++)
			begin
				cf_dl_a[i] <= '0;
				cf_dl_b[i] <= '0;
			end
		end
		else if (ce_i && in_valid_i)
		begin
			cf_phase_reg <= ~cf_phase_reg;
			cf_dl_a[0]   <= in_a_i;
			cf_dl_b[0]   <= in_b_i;
			for (int i = 1; i < NT; i++)
			begin
				cf_dl_a[i] <= cf_dl_a[i-1];
				cf_dl_b[i] <= cf_dl_b[i-1];
			end
		end
	end
	// ==================================================================
	// compensation sequencer
	logic [6:0]        cf_k_reg;     // tap index
	logic              cf_lane_reg;  // 0 for A, 1 for B
	logic [6:0]        cf_mir;       // mirrored tap index
	logic [DW-1:0]     cf_xa, cf_xm;
	logic signed [XW-1:0] cf_x;
	logic signed [DW-1:0] cf_c, cf_y;
	logic signed [AW-1:0] cf_acc;
	logic [DW-1:0]     cf_a_reg, cf_b_reg;
	logic              cf_valid_reg; // one pulse per decimated sample
	always_comb
	begin
		cf_mir = cf_len - 7'h01 - cf_k_reg;
		// both lanes read the same coefficient word
		cf_xa  = cf_lane_reg ? cf_dl_b[cf_k_reg[5:0]] : cf_dl_a[cf_k_reg[5:0]];
		cf_xm  = cf_lane_reg ? cf_dl_b[cf_mir[5:0]] : cf_dl_a[cf_mir[5:0]];
		if (cf_sym_reg)
			cf_x = $signed({cf_xa[DW-1], cf_xa}) + $signed({cf_xm[DW-1], cf_xm});
		else
			cf_x = $signed({cf_xa[DW-1], cf_xa});
		cf_c = $signed({cf_hi_mem[cf_k_reg[5:0]], cf_lo_mem[cf_k_reg[5:0]]});
	end
	rcsf_mac u_cf_mac (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.en_i  (cf_st_reg == SEQ_RUN),
		.clr_i (cf_k_reg == 7'h00),
		.x_i   (cf_x),
		.c_i   (cf_c),
		.acc_o (cf_acc)
	);
	// gain shift of 19 or 18, then round and limit
	rcsf_shape u_cf_shape (
		.acc_i   (cf_acc),
		.shift_i (GAIN_BASE - {4'h0, cf_gain_reg}),
		.y_o     (cf_y)
	);
	// one multiply per cycle; lane B follows lane A in cdma
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cf_st_reg    <= SEQ_IDLE;
			cf_k_reg     <= 7'h00;
			cf_lane_reg  <= 1'b0;
			cf_a_reg     <= '0;
			cf_b_reg     <= '0;
			cf_valid_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			cf_valid_reg <= 1'b0;
			unique case (cf_st_reg)
				SEQ_IDLE:
				begin
					cf_k_reg    <= 7'h00;
					cf_lane_reg <= 1'b0;
					if (cf_start)
						cf_st_reg <= SEQ_RUN;
				end
				SEQ_RUN:
				begin
					// unused taps are never visited
					if (cf_k_reg == cf_iters - 7'h01)
						cf_st_reg <= SEQ_FIN;
					else
						cf_k_reg <= cf_k_reg + 7'h01;
				end
				SEQ_FIN:
				begin
					cf_k_reg <= 7'h00;
					if (!cf_lane_reg && cdma_reg)
					begin
						cf_a_reg    <= cf_y;
						cf_lane_reg <= 1'b1;
						cf_st_reg   <= SEQ_RUN;
					end
					else
					begin
						if (cf_lane_reg)
							cf_b_reg <= cf_y;
						else
							cf_a_reg <= cf_y;
						cf_valid_reg <= 1'b1;
						cf_st_reg    <= SEQ_IDLE;
					end
				end
			endcase
		end
	end
	// ==================================================================
	// shaping input selection and delay lines
	logic          pf_in_valid;
	logic [DW-1:0] pf_in_a;
	logic          pf_start;
	logic [DW-1:0] pf_dl_a [NT];
	logic [DW-1:0] pf_dl_b [NT];
	rcsf_seq_t     pf_st_reg;
	logic          strap_valid_reg;
	logic [DW-1:0] strap_data_reg;
	// the odd half of a pair takes its samples from the even half
	assign pf_in_valid = (dbl_reg == DBL_ODD) ? strap_valid_i : cf_valid_reg;
	assign pf_in_a     = (dbl_reg == DBL_ODD) ? strap_data_i : cf_a_reg;
	assign pf_start    = pf_in_valid && (pf_st_reg == SEQ_IDLE);
	// every input sample shifts in; one that arrives while the sequencer is idle starts a sum
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			strap_valid_reg <= 1'b0;
			strap_data_reg  <= '0;
			for (int i = 0; i < NT; i++)
			begin
				pf_dl_a[i] <= '0;
				pf_dl_b[i] <= '0;
			end
		end
		else if (ce_i)
		begin
			strap_valid_reg <= pf_in_valid && (dbl_reg == DBL_EVEN);
			if (pf_in_valid)
			begin
				// the sample leaving the last used tap goes to the neighbour
				strap_data_reg <= (dbl_reg == DBL_EVEN) ? pf_dl_a[pf_len[5:0] - 6'h01] : '0;
				pf_dl_a[0] <= pf_in_a;
				pf_dl_b[0] <= cf_b_reg;
				for (int i = 1; i < NT; i++)
				begin
					pf_dl_a[i] <= pf_dl_a[i-1];
					pf_dl_b[i] <= pf_dl_b[i-1];
				end
			end
		end
	end
	// ==================================================================
	// shaping sequencer and strap summation
	logic [6:0]        pf_k_reg;
	logic              pf_lane_reg;
	logic [DW-1:0]     pf_xa;
	logic signed [AW-1:0] pf_acc, pf_sum;
	logic signed [DW-1:0] pf_y;
	logic              psum_have_reg;  // neighbour sum waiting
	logic [AW-1:0]     psum_reg;
	logic              pf_need;        // even half waits for the odd sum
	logic              pf_take;        // final step of a shaping sum
	logic              out_valid_reg, psum_valid_reg;
	logic [DW-1:0]     out_a_reg, out_b_reg;
	// lane a waits here so both outputs change under one strobe
	logic [DW-1:0]     pf_a_hold_reg;
	logic [AW-1:0]     psum_out_reg;
	assign pf_xa   = pf_lane_reg ? pf_dl_b[pf_k_reg[5:0]] : pf_dl_a[pf_k_reg[5:0]];
	assign pf_need = (dbl_reg == DBL_EVEN);
	assign pf_sum  = pf_acc + (pf_need ? $signed(psum_reg) : '0);
	assign pf_take = (pf_st_reg == SEQ_FIN) && (!pf_need || psum_have_reg);
	rcsf_mac u_pf_mac (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.en_i  (pf_st_reg == SEQ_RUN),
		.clr_i (pf_k_reg == 7'h00),
		.x_i   ($signed({pf_xa[DW-1], pf_xa})),
		.c_i   ($signed(pf_mem[pf_k_reg[5:0]])),
		.acc_o (pf_acc)
	);
	// one gain shift for both sub-channels
	rcsf_shape u_pf_shape (
		.acc_i   (pf_sum),
		.shift_i (GAIN_BASE - {2'h0, pf_gain_reg}),
		.y_o     (pf_y)
	);
	// an arriving neighbour sum wins over its own consumption
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			psum_have_reg <= 1'b0;
			psum_reg      <= '0;
		end
		else if (ce_i)
		begin
			if (psum_valid_i)
			begin
				psum_have_reg <= 1'b1;
				psum_reg      <= psum_i;
			end
			else if (pf_take && pf_need)
				psum_have_reg <= 1'b0;
		end
	end
	// runs lane A, then lane B in cdma, then publishes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pf_st_reg      <= SEQ_IDLE;
			pf_k_reg       <= 7'h00;
			pf_lane_reg    <= 1'b0;
			out_valid_reg  <= 1'b0;
			out_a_reg      <= '0;
			out_b_reg      <= '0;
			pf_a_hold_reg  <= '0;
			psum_valid_reg <= 1'b0;
			psum_out_reg   <= '0;
		end
		else if (ce_i)
		begin
			out_valid_reg  <= 1'b0;
			psum_valid_reg <= 1'b0;
			unique case (pf_st_reg)
				SEQ_IDLE:
				begin
					pf_k_reg    <= 7'h00;
					pf_lane_reg <= 1'b0;
					if (pf_start)
						pf_st_reg <= SEQ_RUN;
				end
				SEQ_RUN:
				begin
					if (pf_k_reg == pf_len - 7'h01)
						pf_st_reg <= SEQ_FIN;
					else
						pf_k_reg <= pf_k_reg + 7'h01;
				end
				SEQ_FIN:
				begin
					pf_k_reg <= 7'h00;
					if (pf_take && !pf_lane_reg && cdma_reg)
					begin
						pf_a_hold_reg <= pf_y;
						pf_lane_reg   <= 1'b1;
						pf_st_reg   <= SEQ_RUN;
					end
					else if (pf_take)
					begin
						if (dbl_reg == DBL_ODD)
						begin
							// the odd half only hands its raw sum over
							psum_out_reg   <= pf_acc;
							psum_valid_reg <= 1'b1;
						end
						else
						begin
							if (pf_lane_reg)
							begin
								out_a_reg <= pf_a_hold_reg;
								out_b_reg <= pf_y;
							end
							else
								out_a_reg <= pf_y;
							out_valid_reg <= 1'b1;
						end
						pf_st_reg <= SEQ_IDLE;
					end
				end
			endcase
		end
	end
	// ==================================================================
	// register reads, data only in the cycle after the strobe
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_reg <= '0;
		else if (ce_i)
		begin
			rdata_reg <= '0;
			if (re_i)
			begin
				unique case (page)
					PAGE_CTRL:
					begin
						if (idx == REG_CFCFG)
							rdata_reg <= DW'({cf_gain_reg, cf_sym_reg, cf_taps_reg});
						if (idx == REG_PFCFG)
							rdata_reg <= DW'({pf_gain_reg, pf_taps_reg});
						if (idx == REG_MODE)
							rdata_reg <= DW'({cic_reg, dbl_reg, cdma_reg});
						if (idx == REG_STAT)
							rdata_reg <= DW'({cf_over, pf_st_reg != SEQ_IDLE, cf_st_reg != SEQ_IDLE});
						if (idx == REG_LEN)
							rdata_reg <= DW'({pf_total, cf_len});
						if (idx == REG_CIC)
							rdata_reg <= DW'(ncic);
					end
					PAGE_CFHI: rdata_reg <= DW'(cf_hi_mem[idx]);
					PAGE_CFLO: rdata_reg <= DW'(cf_lo_mem[idx]);
					PAGE_PF:   rdata_reg <= pf_mem[idx];
				endcase
			end
		end
	end
	// ==================================================================
	// outputs straight from flip-flops
	assign rdata_o       = rdata_reg;
	assign strap_valid_o = strap_valid_reg;
	assign strap_data_o  = strap_data_reg;
	assign psum_valid_o  = psum_valid_reg;
	assign psum_o        = psum_out_reg;
	assign out_valid_o   = out_valid_reg;
	assign out_a_o       = out_a_reg;
	assign out_b_o       = out_b_reg;
endmodule : rcsf_top
`default_nettype wire

// [src/rcsf_pkg.sv]
// constants and types shared by the receive compensation and shaping filters
package rcsf_pkg;
	// ==================================================================
	// data widths
	localparam int DW = 18;                  // sample and coefficient width
	localparam int XW = 19;                  // pre-added sample width
	localparam int AW = 48;                  // accumulator width
	localparam int RAW = 8;                  // register address width
	// ==================================================================
	// tap limits
	localparam logic [6:0] CF_MIN_TAPS = 7'h0e;  // 14 taps
	localparam logic [6:0] PF_MIN_UMTS = 7'h1c;  // 28 taps
	localparam logic [6:0] PF_MIN_CDMA = 7'h20;  // 32 taps
	localparam logic [6:0] CF_STEP     = 7'h02;  // compensation step
	localparam logic [6:0] PF_STEP     = 7'h04;  // shaping step
	localparam logic [4:0] GAIN_BASE   = 5'h13;  // shift of 19 at gain 0
	// ==================================================================
	// register pages and control offsets
	localparam logic [1:0] PAGE_CTRL = 2'h0;     // control registers
	localparam logic [1:0] PAGE_CFHI = 2'h1;     // compensation coef [17:2]
	localparam logic [1:0] PAGE_CFLO = 2'h2;     // compensation coef [1:0]
	localparam logic [1:0] PAGE_PF   = 2'h3;     // shaping coefficients
	localparam logic [5:0] REG_CFCFG = 6'h00;
	localparam logic [5:0] REG_PFCFG = 6'h01;
	localparam logic [5:0] REG_MODE  = 6'h02;
	localparam logic [5:0] REG_STAT  = 6'h03;
	localparam logic [5:0] REG_LEN   = 6'h04;
	localparam logic [5:0] REG_CIC   = 6'h05;
	// ==================================================================
	// field positions
	localparam int CF_SYM_BIT  = 5;              // symmetry option
	localparam int CF_GAIN_BIT = 6;              // compensation gain bit
	localparam int PF_GAIN_LSB = 4;              // shaping gain [6:4]
	localparam int MODE_DBL_LSB = 1;             // double length [2:1]
	localparam int MODE_CIC_LSB = 3;             // comb ratio [7:3]
	// ==================================================================
	// reset values
	localparam logic [4:0] CF_TAPS_RST = 5'h06;
	localparam logic [3:0] PF_TAPS_RST = 4'h7;
	localparam logic [4:0] CIC_RST     = 5'h03;
	// ==================================================================
	// double length codes
	localparam logic [1:0] DBL_NORMAL = 2'h0;
	localparam logic [1:0] DBL_ODD    = 2'h1;
	localparam logic [1:0] DBL_EVEN   = 2'h2;
	// ==================================================================
	// sequencer states, gray along idle, run, finish
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_RUN  = 2'b01,
		SEQ_FIN  = 2'b11
	} rcsf_seq_t;
endpackage : rcsf_pkg

// [src/rcsf_mac.sv]
// serial multiply-accumulate engine
`timescale 1ns/1ps
`default_nettype none
module rcsf_mac
	import rcsf_pkg::*;
#(
	parameter int XWID = XW,
	parameter int CWID = DW,
	parameter int AWID = AW
)(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   ce_i,
	input  wire logic                   en_i,   // accumulate this cycle
	input  wire logic                   clr_i,  // first product of a sum
	input  wire logic signed [XWID-1:0] x_i,
	input  wire logic signed [CWID-1:0] c_i,
	output logic signed [AWID-1:0]      acc_o
);
	// ==================================================================
	// product and sign extension
	localparam int PW = XWID + CWID;
	logic signed [PW-1:0]   prod;   // full precision product
	logic signed [AWID-1:0] prod_x; // extended to accumulator width
	logic signed [AWID-1:0] acc_reg;
	assign prod   = x_i * c_i;
	assign prod_x = {{(AWID-PW){prod[PW-1]}}, prod};
	// accumulator holds while idle so a sum can wait for its partner
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			acc_reg <= '0;
		else if (ce_i && en_i)
			acc_reg <= clr_i ? prod_x : acc_reg + prod_x;
	end
	assign acc_o = acc_reg;
endmodule : rcsf_mac
`default_nettype wire

// [src/rcsf_shape.sv]
// gain shift, rounding and hard limiting of a filter sum
`timescale 1ns/1ps
`default_nettype none
module rcsf_shape
	import rcsf_pkg::*;
#(
	parameter int AWID = AW,
	parameter int OWID = DW
)(
	input  wire logic signed [AWID-1:0] acc_i,   // full precision sum
	input  wire logic        [4:0]      shift_i, // right shift, at least 1
	output logic signed      [OWID-1:0] y_o
);
	// ==================================================================
	// round half up at full precision, then saturate
	localparam logic signed [AWID:0] YMAX = (AWID+1)'((1 << (OWID-1)) - 1);
	localparam logic signed [AWID:0] YMIN = -YMAX - (AWID+1)'(1);
	logic signed [AWID:0] half;  // weight of the first dropped bit
	logic signed [AWID:0] rnd;   // sum plus rounding constant
	logic signed [AWID:0] sh;    // shifted result before limiting
	always_comb
	begin
		half = (AWID+1)'(1) <<< (shift_i - 5'h01);
		rnd  = $signed({acc_i[AWID-1], acc_i}) + half;
		sh   = rnd >>> shift_i;
		if (sh > YMAX)
			y_o = YMAX[OWID-1:0];
		else if (sh < YMIN)
			y_o = YMIN[OWID-1:0];
		else
			y_o = sh[OWID-1:0];
	end
endmodule : rcsf_shape
`default_nettype wire

// [sim/rcsf_props.sv]
// port checker for the receive compensation and shaping filter
`timescale 1ns/1ps
`default_nettype none
module rcsf_props
	import rcsf_pkg::*;
(
	input wire logic           clk_i,
	input wire logic           rst_i,
	input wire logic [RAW-1:0] addr_i,
	input wire logic           re_i,
	input wire logic [DW-1:0]  rdata_o,
	input wire logic           strap_valid_o,
	input wire logic           psum_valid_o,
	input wire logic           out_valid_o,
	input wire logic [DW-1:0]  out_a_o,
	input wire logic [DW-1:0]  out_b_o
);
	// ==========
	// one domain; clock enable is assumed high, a frozen block is not covered
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	rdata_idle_a: assert property (!re_i |=> rdata_o == '0)
		else $error("read data without a read");
	rst_quiet_a: assert property ($fell(rst_i) |-> !out_valid_o && out_a_o == '0 && rdata_o == '0)
		else $error("outputs not cleared by reset");
	out_pulse_a: assert property (out_valid_o |=> !out_valid_o)
		else $error("output strobe too long");
	// past reset is excluded, a one-edge reset may clear a held output
	out_hold_a: assert property (!$past(rst_i) && !out_valid_o |-> $stable(out_a_o) && $stable(out_b_o))
		else $error("output changed without strobe");
	odd_excl_a: assert property (!(psum_valid_o && out_valid_o))
		else $error("partial sum and output strobe together");
	psum_pulse_a: assert property (psum_valid_o |=> !psum_valid_o)
		else $error("partial sum strobe too long");
	strap_pulse_a: assert property (strap_valid_o |=> !strap_valid_o)
		else $error("delay line strobe too long");
	len_range_a: assert property (re_i && addr_i == 8'h04 |=> rdata_o[6:0] >= CF_MIN_TAPS
		&& rdata_o[6:0] <= 7'h40 && !rdata_o[0] && rdata_o[14:7] >= 8'h1c
		&& rdata_o[14:7] <= 8'h80 && rdata_o[8:7] == 2'h0)
		else $error("filter length out of range");
	ncic_range_a: assert property (re_i && addr_i == 8'h05 |=> rdata_o >= 18'h4 && rdata_o <= 18'h20)
		else $error("comb ratio out of range");
endmodule : rcsf_props
`default_nettype wire

// [sim/rcsf_comb_src.sv]
// comb decimator stand-in sending a dc level at a fixed slow rate
`timescale 1ns/1ps
`default_nettype none
module rcsf_comb_src #(
	parameter int PER = 64  // clocks between samples
)(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [17:0] level_i,  // level to send on lane a
	output logic             valid_o,
	output logic      [17:0] a_o,
	output logic      [17:0] b_o
);
	logic [7:0] cnt_reg;  // sample spacing counter
	logic       hit;      // last clock of a sample period
	assign hit = cnt_reg == 8'(PER - 1);
	// slow rate leaves room for both lanes of both sums
	always_ff @(posedge clk_i)
	begin
		cnt_reg <= (rst_i || hit) ? 8'h00 : cnt_reg + 8'h01;
		valid_o <= !rst_i && hit;
		// lane b is negated; lines toggle between samples so stale data is not trusted
		a_o <= rst_i ? 18'h0 : (hit ? level_i : ~a_o);
		b_o <= rst_i ? 18'h0 : (hit ? -level_i : ~b_o);
	end
endmodule : rcsf_comb_src
`default_nettype wire

// [sim/rcsf_top_tb.sv]
// bench for the receive compensation and shaping filter
`timescale 1ns/1ps
`default_nettype none
module rcsf_top_tb;
	import rcsf_pkg::*;
	// ==========
	// bench signals
	logic           clk_i, vld, strap_valid_o, psum_valid_o, out_valid_o;
	logic           rst_i = 1'b1, we_i = 1'b0, re_i = 1'b0;
	logic [RAW-1:0] addr_i = '0;
	logic [DW-1:0]  wdata_i = '0, lvl = '0;
	logic [DW-1:0]  rdata_o, sa, sb, strap_data_o, out_a_o, out_b_o;
	logic [AW-1:0]  psum_i = '0, psum_o;
	int             mismatches = 0, n_tests = 0;
	// ==========
	// block and source; strap and partial sum inputs share the sample strobe
	rcsf_top u_dut (.clk_i, .rst_i, .ce_i(1'b1), .addr_i, .wdata_i, .we_i, .re_i,
		.rdata_o, .in_valid_i(vld), .in_a_i(sa), .in_b_i(sb), .strap_valid_i(vld),
		.strap_data_i(sa), .psum_valid_i(vld), .psum_i, .strap_valid_o, .strap_data_o,
		.psum_valid_o, .psum_o, .out_valid_o, .out_a_o, .out_b_o);
	rcsf_comb_src u_src (.clk_i, .rst_i, .level_i(lvl), .valid_o(vld), .a_o(sa), .b_o(sb));
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// ==========
	// shared checks and bus cycles
	task automatic chk(input logic [AW-1:0] got, input logic [AW-1:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] ad, input logic [17:0] d);
		@(posedge clk_i);
		we_i <= 1'b1;
		addr_i <= ad;
		wdata_i <= d;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] ad, input logic [17:0] e);
		@(posedge clk_i);
		re_i <= 1'b1;
		addr_i <= ad;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask : rd
	// count strobes of one kind under a bound so a silent block cannot hang
	task automatic wv(input int w, input int n);
		int k;
		logic [2:0] f;
		k = 0;
		while (n > 0 && k < 9000)
		begin
			@(posedge clk_i);
			#1 k++;
			f = {strap_valid_o, psum_valid_o, out_valid_o};
			if (f[w] === 1'b1)
				n--;
		end
		chk(n, 0);
	endtask : wv
	// dc level through one coefficient; three outputs flush older samples
	task automatic run(input logic [17:0] x, cf, pf, ea);
		wr(8'h00, cf);
		wr(8'h01, pf);
		lvl <= x;
		wv(0, 3);
		chk(out_a_o, ea);
	endtask : run
	// ==========
	// scenarios
	task automatic t_regs;
		rd(8'h00, 18'h6);
		rd(8'h01, 18'h7);
		rd(8'h05, 18'h4);
		rd(8'h04, 18'h100e);
		rd(8'h3f, 18'h0);
		wr(8'h00, 18'h1f);
		wr(8'h01, 18'h5);
		rd(8'h04, 18'h0e40);
		wr(8'h02, 18'hf9);
		rd(8'h04, 18'h1040);
		rd(8'h05, 18'h20);
		wr(8'h02, 18'h1c);
		rd(8'h04, 18'h1c40);
		wr(8'h01, 18'hf);
		rd(8'h04, 18'h4040);
		wr(8'h02, 18'h18);
		$display("registers done");
	endtask : t_regs
	task automatic t_gain;
		wr(8'h40, 18'h4000);
		wr(8'hc0, 18'h10000);
		for (int g = 0; g < 8; g++)
			run(18'h1000, 18'h46, 18'((g << 4) | 7), 18'(1 << (7 + g)));
		run(18'h1000, 18'h06, 18'h07, 18'h40);
		run(18'h1000, 18'h66, 18'h07, 18'h100);
		run(18'h1004, 18'h06, 18'h77, 18'h2010);
		run(18'h10000, 18'h46, 18'h77, 18'h1ffff);
		run(18'h30000, 18'h46, 18'h77, 18'h20000);
		$display("gain and limits done");
	endtask : t_gain
	task automatic t_cdma;
		wr(8'h02, 18'h79);
		run(18'h1000, 18'h46, 18'h07, 18'h80);
		chk(out_b_o, 18'h3ff80);
		wr(8'h00, 18'h1f);
		rd(8'h03, 18'h4);
		$display("shared lanes done");
	endtask : t_cdma
	task automatic t_strap;
		@(posedge clk_i);
		psum_i <= 48'h4000000;
		wr(8'h02, 18'h1c);
		run(18'h1000, 18'h46, 18'h07, 18'h100);
		wv(2, 40);
		chk(strap_data_o, 18'h400);
		wr(8'h02, 18'h1a);
		wv(1, 3);
		chk(psum_o, 48'h10000000);
		$display("strapped pair done");
	endtask : t_strap
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_gain;
		t_cdma;
		t_strap;
		test_done;
	end
	initial
	begin
		#200us;
		mismatches++;
		test_done;
	end
endmodule : rcsf_top_tb
bind rcsf_top rcsf_props u_props (.clk_i, .rst_i, .addr_i, .re_i, .rdata_o, .strap_valid_o,
	.psum_valid_o, .out_valid_o, .out_a_o, .out_b_o);
`default_nettype wire
